// File: hw/aioh_defines.vh
`ifndef AIOH_DEFINES_VH
`define AIOH_DEFINES_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define AIOH_OFS_RESULT_LO   5'h00
`define AIOH_OFS_RESULT_HI   5'h01
`define AIOH_OFS_SW_TRIGGER  5'h01
`define AIOH_OFS_GAIN0       5'h02
`define AIOH_OFS_GAIN1       5'h03
`define AIOH_OFS_GAIN2       5'h04
`define AIOH_OFS_GAIN3       5'h05
`define AIOH_OFS_RANGE       5'h06
`define AIOH_OFS_REPEAT      5'h07
`define AIOH_OFS_CT0         5'h08
`define AIOH_OFS_CT1         5'h09
`define AIOH_OFS_CT2         5'h0a
`define AIOH_OFS_CT3         5'h0b
`define AIOH_OFS_DAC0_LO     5'h0c
`define AIOH_OFS_DAC0_HI     5'h0d
`define AIOH_OFS_DAC1_LO     5'h0e
`define AIOH_OFS_DAC1_HI     5'h0f
`define AIOH_OFS_DAC_MODE    5'h10
`define AIOH_OFS_TRIG_CFG    5'h11
`define AIOH_OFS_STATUS      5'h12
`define AIOH_OFS_IRQ         5'h13

// ----------------------------------------
// Field positions and encodings
// ----------------------------------------
`define AIOH_SRC_SOFTWARE    2'h0
`define AIOH_SRC_TIMER       2'h1
`define AIOH_SRC_EXTERNAL    2'h2
`define AIOH_TRIG_SWEEP_BIT  2
`define AIOH_TRIG_POL_BIT    3
`define AIOH_TRIG_CT0_BIT    4
`define AIOH_DAC_SIMUL_BIT   0
`define AIOH_FLG_EOC         0
`define AIOH_FLG_SWEEP_DONE  1
`define AIOH_FLG_HALF        2
`define AIOH_FLG_FULL        3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define AIOH_RST_BYTE        8'h00
`define AIOH_RST_GAINS       32'h00000000
`define AIOH_RST_DAC         12'h000
`define AIOH_RST_TRIG        5'h00
`define AIOH_RST_FLAGS       4'h0
`define AIOH_UNMAPPED_READ   8'h00

`endif

// File: hw/aioh_front_end.v
// Notes on behaviour
// - Trigger config write arms timer/external sources
// - Software source starts only on offset 1 write
// - Each offset 1 write while idle with software source gives one start
// - Word access only at even offsets
// - Word read at 0 pops one result
// - Byte 0 low, byte 1 high; pop on 1
// - Offsets 2-5 hold sixteen two-bit gains
// - Stored gain code applied on conversion
// - Offset 6 holds first and last channel
// - Offset 7 holds eight-bit repeat count
// - Counter zero never joins conversion triggering
// - Counter one output clocks counter two
// - Counter two output triggers and drives pin
// - Twelve-bit DAC 0 code over C/D
// - Simultaneous mode holds DAC 0 until DAC 1
// - Trigger register: source, sweep, polarity, clock
// - Status bits 5-7 active-low empty/half/full
// - Flag register read returns and clears flags
// - DAC mode bit 0 selects simultaneous update
`include "aioh_defines.vh"
`default_nettype none

module aioh_front_end #(
	parameter RES_W = 16,
	parameter DAC_W = 12
) (
	// System
	input  wire               clk,
	input  wire               sys_rst,
	// Host I/O pins
	input  wire [4:0]         io_addr,
	input  wire [15:0]        io_wdata,
	input  wire               io_sel_n,
	input  wire               io_rd_n,
	input  wire               io_wr_n,
	input  wire               io_word,
	output reg  [15:0]        io_rdata_r,
	output reg                io_rdata_oe_r,
	// Board jumpers
	input  wire [4:0]         jumper_pins,
	// Result FIFO
	input  wire [RES_W-1:0]   fifo_rd_data,
	input  wire               fifo_empty,
	input  wire               fifo_half,
	input  wire               fifo_full,
	output reg                fifo_pop_r,
	output reg                fifo_push_r,
	output reg  [RES_W-1:0]   fifo_push_data_r,
	// Converter
	input  wire               adc_done,
	input  wire [RES_W-1:0]   adc_result,
	output reg                adc_start_r,
	output reg  [3:0]         adc_channel_r,
	output reg  [1:0]         channel_gain_code_r,
	// Counter/timer block
	input  wire               ct1_out,
	input  wire               ct2_out,
	input  wire [15:0]        ct_rdata,
	output reg  [1:0]         ct_wr_r,
	output reg  [1:0]         ct_rd_r,
	output reg  [1:0]         ct_addr_r,
	output reg  [15:0]        ct_wdata_r,
	output reg                ct2_clk_r,
	output reg                ct2_pin_r,
	output reg                counter0_clock_select_r,
	// DAC 0
	output reg  [DAC_W-1:0]   dac_code_r
);

	// ----------------------------------------
	// Sequencer states
	// ----------------------------------------
	localparam [2:0] S_IDLE  = 3'b001;
	localparam [2:0] S_START = 3'b010;
	localparam [2:0] S_WAIT  = 3'b100;

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	// Readback byte for one lane; no side effects here
	function [7:0] rd_byte;
		input [4:0]  a;
		input [15:0] res;
		input [7:0]  stat;
		input [3:0]  flg;
		begin
			case (a)
				`AIOH_OFS_RESULT_LO: rd_byte = res[7:0];
				`AIOH_OFS_RESULT_HI: rd_byte = res[15:8];
				`AIOH_OFS_STATUS:    rd_byte = stat;
				`AIOH_OFS_IRQ:       rd_byte = {flg, 4'h0};
				default:             rd_byte = `AIOH_UNMAPPED_READ;
			endcase
		end
	endfunction

	// Gain code of one channel out of the packed table
	function [1:0] gain_of;
		input [31:0] g;
		input [3:0]  ch;
		begin
			gain_of = g[{ch, 1'b0} +: 2];
		end
	endfunction

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	reg  [31:0] sync1_r;               // First stage, read by stage two only
	reg  [31:0] sync2_r;               // Settled pin image
	wire [31:0] pins_raw = {jumper_pins, ct2_out, ct1_out, io_word,
		io_sel_n, io_rd_n, io_wr_n, io_addr, io_wdata};

	wire [15:0] wdata_s  = sync2_r[15:0];
	wire [4:0]  addr_s   = sync2_r[20:16];
	wire        wr_n_s   = sync2_r[21];
	wire        rd_n_s   = sync2_r[22];
	wire        sel_n_s  = sync2_r[23];
	wire        word_s   = sync2_r[24];
	wire        ct1_s    = sync2_r[25];
	wire        ct2_s    = sync2_r[26];
	wire [4:0]  jump_s   = sync2_r[31:27];

	// Address and data settle before the strobe, so two stages suffice
	always @(posedge clk) begin
		if (sys_rst) begin
			sync1_r <= 32'h00e00000;
			sync2_r <= 32'h00e00000;
		end else begin
			sync1_r <= pins_raw;
			sync2_r <= sync1_r;
		end
	end

	// ----------------------------------------
	// Strobe edges and access decode
	// ----------------------------------------
	reg  wr_d_r;                       // Previous write strobe level
	reg  rd_d_r;                       // Previous read strobe level
	reg  ct2_d_r;                      // Previous counter two level
	reg  half_d_r;                     // Previous half-full level
	reg  full_d_r;                     // Previous full level

	// Word access at an odd offset is dropped whole
	wire acc_ok  = ~word_s | ~addr_s[0];
	wire wr_fall = ~sel_n_s & ~wr_n_s & wr_d_r & acc_ok;
	wire rd_fall = ~sel_n_s & ~rd_n_s & rd_d_r & acc_ok;

	always @(posedge clk) begin
		if (sys_rst) begin
			wr_d_r   <= 1'b1;
			rd_d_r   <= 1'b1;
			ct2_d_r  <= 1'b0;
			half_d_r <= 1'b0;
			full_d_r <= 1'b0;
		end else begin
			wr_d_r   <= wr_n_s;
			rd_d_r   <= rd_n_s;
			ct2_d_r  <= ct2_s;
			half_d_r <= fifo_half;
			full_d_r <= fifo_full;
		end
	end

	// ----------------------------------------
	// Write side registers
	// ----------------------------------------
	reg [31:0] gains_r;                // Two bits per channel
	reg [3:0]  first_channel_r;        // Sweep start
	reg [3:0]  last_channel_r;         // Sweep end
	reg [7:0]  repeat_count_r;         // Extra samples per channel
	reg [4:0]  trig_cfg_r;             // Source, sweep, polarity, clock
	reg        armed_r;                // Counter two edges accepted
	reg        sw_start_r;             // One-cycle software start
	reg        simul_r;                // Simultaneous DAC update
	reg [11:0] dac0_stage_r;           // Code awaiting update
	reg        dac0_pend_r;            // DAC 0 was written
	reg        dac1_wr_r;              // DAC 1 was written

	always @(posedge clk) begin : wr_blk
		reg [4:0] wa;
		reg [7:0] wd;
		integer   ln;
		if (sys_rst) begin
			gains_r         <= `AIOH_RST_GAINS;
			first_channel_r <= 4'h0;
			last_channel_r  <= 4'h0;
			repeat_count_r  <= `AIOH_RST_BYTE;
			trig_cfg_r      <= `AIOH_RST_TRIG;
			armed_r         <= 1'b0;
			sw_start_r      <= 1'b0;
			simul_r         <= 1'b0;
			dac0_stage_r    <= `AIOH_RST_DAC;
			dac0_pend_r     <= 1'b0;
			dac1_wr_r       <= 1'b0;
			ct_wr_r         <= 2'h0;
			ct_wdata_r      <= 16'h0000;
		end else begin
			sw_start_r  <= 1'b0;
			dac0_pend_r <= 1'b0;
			dac1_wr_r   <= 1'b0;
			ct_wr_r     <= 2'h0;
			// A word write is two byte writes, low lane first
			for (ln = 0; ln < 2; ln = ln + 1) begin
				wa = addr_s | ln[4:0];
				wd = (ln == 0) ? wdata_s[7:0] : wdata_s[15:8];
				if (word_s == 1'b0 && ln == 0) begin
					wd = wdata_s[7:0];
				end
				if (wr_fall && (ln == 0 || word_s)) begin
					case (wa)
						`AIOH_OFS_SW_TRIGGER: begin
							sw_start_r <= 1'b1;
						end
						`AIOH_OFS_GAIN0: gains_r[7:0]   <= wd;
						`AIOH_OFS_GAIN1: gains_r[15:8]  <= wd;
						`AIOH_OFS_GAIN2: gains_r[23:16] <= wd;
						`AIOH_OFS_GAIN3: gains_r[31:24] <= wd;
						`AIOH_OFS_RANGE: begin
							first_channel_r <= wd[3:0];
							last_channel_r  <= wd[7:4];
						end
						`AIOH_OFS_REPEAT: repeat_count_r <= wd;
						`AIOH_OFS_CT0, `AIOH_OFS_CT1,
						`AIOH_OFS_CT2, `AIOH_OFS_CT3: begin
							// Byte lane chosen by the odd address bit
							ct_wr_r[wa[0]] <= 1'b1;
							ct_wdata_r[{wa[0], 3'h0} +: 8] <= wd;
						end
						`AIOH_OFS_DAC0_LO: begin
							dac0_stage_r[7:0] <= wd;
							dac0_pend_r       <= 1'b1;
						end
						`AIOH_OFS_DAC0_HI: begin
							// Upper nibble is ignored
							dac0_stage_r[11:8] <= wd[3:0];
							dac0_pend_r        <= 1'b1;
						end
						`AIOH_OFS_DAC1_LO, `AIOH_OFS_DAC1_HI: begin
							dac1_wr_r <= 1'b1;
						end
						`AIOH_OFS_DAC_MODE: begin
							simul_r <= wd[`AIOH_DAC_SIMUL_BIT];
						end
						`AIOH_OFS_TRIG_CFG: begin
							trig_cfg_r <= wd[4:0];
							// Timer and external arm at once
							armed_r <= (wd[1:0] == `AIOH_SRC_TIMER) ||
								(wd[1:0] == `AIOH_SRC_EXTERNAL);
						end
						default: begin
							// Unmapped or read-only: write ignored
						end
					endcase
				end
			end
		end
	end

	// ----------------------------------------
	// DAC 0 output and counter routing
	// ----------------------------------------
	// Update lags the host write by one cycle, which no DAC notices
	always @(posedge clk) begin
		if (sys_rst) begin
			dac_code_r              <= `AIOH_RST_DAC;
			ct2_clk_r               <= 1'b0;
			ct2_pin_r               <= 1'b0;
			counter0_clock_select_r <= 1'b0;
		end else begin
			if ((dac0_pend_r && !simul_r) || (dac1_wr_r && simul_r)) begin
				dac_code_r <= dac0_stage_r;
			end
			ct2_clk_r <= ct1_s;
			ct2_pin_r <= ct2_s;
			// Counter zero only picks its clock; it never starts sweeps
			counter0_clock_select_r <= trig_cfg_r[`AIOH_TRIG_CT0_BIT];
		end
	end

	// ----------------------------------------
	// Conversion sequencer
	// ----------------------------------------
	reg  [2:0] state_r;                // One-hot state
	reg  [3:0] chan_r;                 // Working channel of the sweep
	reg  [7:0] reps_r;                 // Samples taken on this channel
	reg        sweep_end_r;            // Sweep finished this cycle

	wire [1:0] src    = trig_cfg_r[1:0];
	wire       pol    = trig_cfg_r[`AIOH_TRIG_POL_BIT];
	wire       ct2_ev = pol ? (ct2_d_r & ~ct2_s) : (~ct2_d_r & ct2_s);
	// Counter two edge is the only hardware trigger
	wire start_evt = (sw_start_r && src == `AIOH_SRC_SOFTWARE) ||
		(armed_r && ct2_ev);

	always @(posedge clk) begin
		if (sys_rst) begin
			state_r             <= S_IDLE;
			chan_r              <= 4'h0;
			reps_r              <= 8'h00;
			sweep_end_r         <= 1'b0;
			adc_start_r         <= 1'b0;
			adc_channel_r       <= 4'h0;
			channel_gain_code_r <= 2'h0;
			fifo_push_r         <= 1'b0;
			fifo_push_data_r    <= {RES_W{1'b0}};
		end else begin
			adc_start_r <= 1'b0;
			fifo_push_r <= 1'b0;
			sweep_end_r <= 1'b0;
			case (state_r)
				S_IDLE: begin
					// Starts during a sweep are dropped
					if (start_evt) begin
						// Output channel waits for the start pulse
						chan_r        <= first_channel_r;
						reps_r        <= 8'h00;
						state_r       <= S_START;
					end
				end
				S_START: begin
					adc_start_r         <= 1'b1;
					adc_channel_r       <= chan_r;
					channel_gain_code_r <= gain_of(gains_r, chan_r);
					state_r             <= S_WAIT;
				end
				S_WAIT: begin
					if (adc_done) begin
						fifo_push_r      <= 1'b1;
						fifo_push_data_r <= adc_result;
						if (reps_r != repeat_count_r) begin
							reps_r  <= reps_r + 8'h01;
							state_r <= S_START;
						end else if (trig_cfg_r[`AIOH_TRIG_SWEEP_BIT] &&
							chan_r != last_channel_r) begin
							chan_r        <= chan_r + 4'h1;
							reps_r        <= 8'h00;
							state_r       <= S_START;
						end else begin
							sweep_end_r <= 1'b1;
							state_r     <= S_IDLE;
						end
					end
				end
				default: state_r <= S_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Read side, result pops and event flags
	// ----------------------------------------
	reg  [3:0] flags_r;                // Full, half, sweep_done, eoc
	reg        ct_cap_r;               // Counter readback due next cycle

	wire [7:0] status_b = {~fifo_full, ~fifo_half, ~fifo_empty,
		jump_s};
	wire [3:0] flag_set;
	assign flag_set[`AIOH_FLG_EOC]        = fifo_push_r;
	assign flag_set[`AIOH_FLG_SWEEP_DONE] = sweep_end_r;
	assign flag_set[`AIOH_FLG_HALF]       = fifo_half & ~half_d_r;
	assign flag_set[`AIOH_FLG_FULL]       = fifo_full & ~full_d_r;

	always @(posedge clk) begin : rd_blk
		reg [4:0] ra;
		reg [3:0] clr;
		integer   ln;
		clr = 4'h0;
		if (sys_rst) begin
			io_rdata_r    <= 16'h0000;
			io_rdata_oe_r <= 1'b0;
			fifo_pop_r    <= 1'b0;
			flags_r       <= `AIOH_RST_FLAGS;
			ct_rd_r       <= 2'h0;
			ct_addr_r     <= 2'h0;
			ct_cap_r      <= 1'b0;
		end else begin
			fifo_pop_r <= 1'b0;
			ct_rd_r    <= 2'h0;
			ct_cap_r   <= 1'b0;
			if (rd_fall) begin
				io_rdata_oe_r <= 1'b1;
				io_rdata_r    <= 16'h0000;
				for (ln = 0; ln < 2; ln = ln + 1) begin
					ra = addr_s | ln[4:0];
					if (ln == 0 || word_s) begin
						io_rdata_r[ln*8 +: 8] <= rd_byte(ra, fifo_rd_data,
							status_b, flags_r);
						// Pop only after the high byte leaves
						if (ra == `AIOH_OFS_RESULT_HI && !fifo_empty) begin
							fifo_pop_r <= 1'b1;
						end
						if (ra == `AIOH_OFS_IRQ) begin
							clr = flags_r;
						end
						if (ra[4:2] == 3'h2) begin
							ct_rd_r[ra[0]] <= 1'b1;
							ct_addr_r      <= {ra[1], 1'b0};
							ct_cap_r       <= 1'b1;
						end
					end
				end
				// A byte read at an odd offset sits in the low lane
				if (!word_s && addr_s[0]) begin
					io_rdata_r[7:0] <= rd_byte(addr_s, fifo_rd_data,
						status_b, flags_r);
				end
			end else if (rd_n_s || sel_n_s) begin
				io_rdata_oe_r <= 1'b0;
			end
			if (wr_fall && addr_s[4:2] == 3'h2) begin
				ct_addr_r <= {addr_s[1], 1'b0};
			end
			if (ct_cap_r) begin
				io_rdata_r <= (word_s || !addr_s[0]) ? ct_rdata :
					{8'h00, ct_rdata[15:8]};
			end
			// An event in the clearing cycle survives
			flags_r <= (flags_r & ~clr) | flag_set;
		end
	end

endmodule

`default_nettype wire

// File: sim/aioh_chk.sv
`default_nettype none
module aioh_chk #(
	parameter RES_W = 16,
	parameter DAC_W = 12
) (
	// Clock, reset, host pins
	input wire logic             clk,
	input wire logic             sys_rst,
	input wire logic [4:0]       io_addr,
	input wire logic             io_sel_n,
	input wire logic             io_rd_n,
	input wire logic             io_wr_n,
	input wire logic             io_word,
	input wire logic             io_rdata_oe_r,
	// Result path
	input wire logic             fifo_pop_r,
	input wire logic             fifo_push_r,
	input wire logic [RES_W-1:0] fifo_push_data_r,
	input wire logic             adc_done,
	input wire logic [RES_W-1:0] adc_result,
	input wire logic             adc_start_r,
	input wire logic [3:0]       adc_channel_r,
	input wire logic [1:0]       channel_gain_code_r,
	// Counters and DAC
	input wire logic             ct1_out,
	input wire logic             ct2_out,
	input wire logic             ct2_clk_r,
	input wire logic             ct2_pin_r,
	input wire logic             counter0_clock_select_r,
	input wire logic [DAC_W-1:0] dac_code_r
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// Word read held at an odd offset
	sequence s_odd_word;
		(!io_sel_n && !io_rd_n && io_word && io_addr[0]) [*6];
	endsequence
	a_odd_refused: assert property (s_odd_word |-> !io_rdata_oe_r)
		else $error("odd word read answered");
	a_oe_cause: assert property ($rose(io_rdata_oe_r) |->
		!$past(io_rd_n, 3) && !$past(io_sel_n, 3))
		else $error("read data without read strobe");
	a_pop_on_read: assert property (fifo_pop_r |->
		$rose(io_rdata_oe_r) && io_addr[4:1] == 4'h0)
		else $error("pop outside result read");
	a_pop_once: assert property (fifo_pop_r |=> !fifo_pop_r [*4])
		else $error("more than one pop");
	a_push_data: assert property (adc_done |=>
		fifo_push_r && fifo_push_data_r == $past(adc_result))
		else $error("result not pushed");
	a_chan_held: assert property (!adc_start_r |->
		$stable(adc_channel_r) && $stable(channel_gain_code_r))
		else $error("channel or gain moved");
	a_ct2_clock: assert property ($rose(ct1_out) |-> ##[1:4] ct2_clk_r)
		else $error("counter two clock not following");
	a_ct2_pin: assert property ($fell(ct2_out) |-> ##[1:4] !ct2_pin_r)
		else $error("counter two pin not following");
	a_dac_write: assert property (!$stable(dac_code_r) |->
		!io_wr_n && !io_sel_n)
		else $error("dac moved without write");
	a_cfg_write: assert property (!$stable(counter0_clock_select_r) |->
		!io_wr_n && io_addr == 5'h11)
		else $error("clock select moved without write");
endmodule
`default_nettype wire

// File: sim/aioh_host.sv
`default_nettype none
module aioh_host (
	// Clock and read answer
	input  wire logic        clk,
	input  wire logic [15:0] io_rdata_r,
	input  wire logic        io_rdata_oe_r,
	// Host lines
	output var  logic [4:0]  io_addr,
	output var  logic [15:0] io_wdata,
	output var  logic        io_sel_n,
	output var  logic        io_rd_n,
	output var  logic        io_wr_n,
	output var  logic        io_word
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		io_addr = 5'h1f;
		io_wdata = 16'hffff;
		io_sel_n = 1'b1;
		io_rd_n = 1'b1;
		io_wr_n = 1'b1;
		io_word = 1'b0;
	end
	// One cycle: strobe low six clocks, high five; word only at even
	// offsets unless a refusal is wanted on purpose
	task automatic access(input logic rd, w, input logic [4:0] a,
		input logic [15:0] d, output logic [16:0] r);
		r = 17'h0;
		@(negedge clk);
		io_addr = a;
		io_wdata = d;
		io_word = w;
		io_sel_n = 1'b0;
		io_rd_n = !rd;
		io_wr_n = rd;
		repeat (6) @(posedge clk);
		if (rd && io_rdata_oe_r === 1'b1)
			r = {1'b1, io_rdata_r};
		@(negedge clk);
		// Released lines show the inverse, not a stale value
		io_sel_n = 1'b1;
		io_rd_n = 1'b1;
		io_wr_n = 1'b1;
		io_addr = ~a;
		io_wdata = ~d;
		io_word = ~w;
		repeat (5) @(negedge clk);
	endtask
endmodule
`default_nettype wire

// File: sim/analog_io_host_register_front_end_bench.sv
`default_nettype none
module analog_io_host_register_front_end_bench;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {logic [16:0] v; logic [16:0] m;} aioh_note_t;
	logic clk, sys_rst, io_sel_n, io_rd_n, io_wr_n, io_word, io_rdata_oe_r;
	logic fifo_empty, fifo_half, fifo_full, fifo_pop_r, fifo_push_r;
	logic adc_done, adc_start_r, ct1_out, ct2_out, ct2_clk_r, ct2_pin_r;
	logic counter0_clock_select_r;
	logic [4:0] io_addr, jumper_pins;
	logic [15:0] io_wdata, io_rdata_r, ct_rdata, fifo_rd_data, adc_result;
	logic [15:0] fifo_push_data_r, ct_wdata_r;
	logic [3:0] adc_channel_r;
	logic [1:0] channel_gain_code_r, ct_wr_r, ct_rd_r, ct_addr_r;
	logic [11:0] dac_code_r;
	logic [31:0] gains;
	logic [16:0] obs;
	logic [15:0] fq[$], res_q[$];
	logic [5:0] st_q[$];
	aioh_note_t nq[$];
	int miscompares, num_checks, cyc, cnt;
	event obs_ev;
	aioh_front_end DUT (.clk, .sys_rst, .io_addr, .io_wdata, .io_sel_n,
		.io_rd_n, .io_wr_n, .io_word, .io_rdata_r, .io_rdata_oe_r,
		.jumper_pins, .fifo_rd_data, .fifo_empty, .fifo_half, .fifo_full,
		.fifo_pop_r, .fifo_push_r, .fifo_push_data_r, .adc_done, .adc_result,
		.adc_start_r, .adc_channel_r, .channel_gain_code_r, .ct1_out,
		.ct2_out, .ct_rdata, .ct_wr_r, .ct_rd_r, .ct_addr_r, .ct_wdata_r,
		.ct2_clk_r, .ct2_pin_r, .counter0_clock_select_r, .dac_code_r);
	aioh_host u_host (.clk, .io_rdata_r, .io_rdata_oe_r, .io_addr,
		.io_wdata, .io_sel_n, .io_rd_n, .io_wr_n, .io_word);
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task chk(input string n, input logic [16:0] e, g, m);
		num_checks++;
		if (((g ^ e) & m) !== 17'h0) begin
			miscompares++;
			$display("unexpected %s: expected %h, seen %h", n, e & m, g & m);
		end
	endtask
	task print_verdict;
		$display("checks %0d, miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Notes compared when an observation lands
	always @(obs_ev) begin
		if (nq.size() == 0)
			chk("note", 17'h0, 17'h1, 17'h1);
		else
			chk("value", nq[0].v, obs, nq[0].m);
		if (nq.size() != 0)
			void'(nq.pop_front());
	end
	// Every start must have been noted, with channel and gain
	always @(posedge clk) if (adc_start_r === 1'b1) begin
		if (st_q.size() == 0)
			chk("start", 17'h0, 17'h1, 17'h1);
		else
			chk("start", {11'h0, st_q.pop_front()},
				{11'h0, adc_channel_r, channel_gain_code_r}, 17'h3f);
	end
	// Converter answers in three clocks; FIFO falls through
	always @(negedge clk) begin
		adc_done = 1'b0;
		if (cnt == 1) begin
			adc_result = 16'($urandom);
			adc_done = 1'b1;
			res_q.push_back(adc_result);
		end
		if (cnt != 0)
			cnt--;
		if (adc_start_r === 1'b1)
			cnt = 3;
		fifo_rd_data = fq.size() ? fq[0] : ~fifo_rd_data;
		fifo_empty = fq.size() == 0;
		fifo_half = fq.size() >= 8;
		fifo_full = fq.size() >= 16;
	end
	always @(posedge clk) begin
		if (fifo_push_r === 1'b1)
			fq.push_back(fifo_push_data_r);
		if (fifo_pop_r === 1'b1 && fq.size() != 0)
			void'(fq.pop_front());
		cyc++;
		if (cyc == 6000) begin
			miscompares++;
			print_verdict;
		end
	end
	task rd(input logic w, input logic [4:0] a, input logic [16:0] e, m);
		nq.push_back('{e, m});
		u_host.access(1'b1, w, a, 16'h0, obs);
		->obs_ev;
	endtask
	task wr(input logic w, input logic [4:0] a, input logic [15:0] d);
		logic [16:0] r;
		u_host.access(1'b0, w, a, d, r);
	endtask
	task dac_note(input logic [11:0] e);
		nq.push_back('{{5'h0, e}, 17'hfff});
		obs = {5'h0, dac_code_r};
		->obs_ev;
	endtask
	task exp_sweep(input logic [3:0] f, l, input logic scan, input int rep);
		logic [3:0] c;
		c = f;
		forever begin
			repeat (rep + 1) st_q.push_back({c, gains[2 * c +: 2]});
			if (!scan || c == l)
				break;
			c++;
		end
	endtask
	task wait_res(input int n);
		for (int i = 0; i < 400 && res_q.size() < n; i++) @(negedge clk);
		repeat (8) @(negedge clk);
	endtask
	task res_word;
		rd(1'b1, 5'h00, {1'b1, res_q.pop_front()}, 17'h1ffff);
	endtask
	task res_bytes;
		logic [15:0] v;
		v = res_q.pop_front();
		rd(1'b0, 5'h00, {9'h100, v[7:0]}, 17'h1ffff);
		rd(1'b0, 5'h00, {9'h100, v[7:0]}, 17'h1ffff);
		rd(1'b0, 5'h01, {9'h100, v[15:8]}, 17'h1ffff);
	endtask
	// Counter edge pair; ct1 moves along to exercise the cascade
	task pulse_ct2;
		repeat (3) @(negedge clk);
		ct2_out = 1'b1;
		ct1_out = 1'b1;
		repeat (6) @(negedge clk);
		ct2_out = 1'b0;
		ct1_out = 1'b0;
		repeat (6) @(negedge clk);
	endtask
	initial begin
		logic [15:0] d, d2;
		sys_rst = 1'b1;
		ct1_out = 1'b0;
		ct2_out = 1'b0;
		adc_done = 1'b0;
		adc_result = 16'h0;
		fifo_rd_data = 16'h0;
		fifo_empty = 1'b1;
		fifo_half = 1'b0;
		fifo_full = 1'b0;
		void'($urandom(32'h75212184));
		gains = $urandom;
		jumper_pins = 5'($urandom);
		ct_rdata = 16'($urandom);
		repeat (2) @(negedge clk);
		sys_rst = 1'b0;
		wr(1'b1, 5'h02, gains[15:0]);
		wr(1'b1, 5'h04, gains[31:16]);
		wr(1'b0, 5'h06, 16'h0052);
		wr(1'b0, 5'h07, 16'h0001);
		wr(1'b0, 5'h09, 16'h0034);
		nq.push_back('{17'h00034, 17'h000ff});
		obs = {9'h0, ct_wdata_r[15:8]};
		->obs_ev;
		rd(1'b1, 5'h08, {1'b1, ct_rdata}, 17'h1ffff);
		wr(1'b0, 5'h11, 16'h0004);
		pulse_ct2;
		exp_sweep(4'h2, 4'h5, 1'b1, 1);
		wr(1'b0, 5'h01, 16'($urandom));
		wait_res(8);
		rd(1'b0, 5'h13, 17'h10070, 17'h100f0);
		rd(1'b0, 5'h13, 17'h10000, 17'h100f0);
		rd(1'b0, 5'h12, {1'b1, 8'h00, 3'b101, jumper_pins}, 17'h1ffff);
		res_word;
		rd(1'b1, 5'h01, 17'h0, 17'h1ffff);
		rd(1'b0, 5'h07, 17'h10000, 17'h1ffff);
		for (int i = 0; i < 3; i++) res_bytes;
		while (res_q.size() != 0) res_word;
		wr(1'b0, 5'h06, 16'h003c);
		wr(1'b0, 5'h11, 16'h0001);
		exp_sweep(4'hc, 4'h3, 1'b0, 1);
		pulse_ct2;
		wait_res(2);
		while (res_q.size() != 0) res_word;
		wr(1'b0, 5'h11, 16'h001a);
		exp_sweep(4'hc, 4'h3, 1'b0, 1);
		pulse_ct2;
		wait_res(2);
		while (res_q.size() != 0) res_word;
		wr(1'b0, 5'h11, 16'h0000);
		d = $urandom;
		wr(1'b0, 5'h0c, d);
		wr(1'b0, 5'h0d, {8'h00, 4'hf, d[11:8]});
		dac_note(d[11:0]);
		wr(1'b0, 5'h10, 16'h0001);
		d2 = $urandom;
		wr(1'b1, 5'h0c, d2 | 16'hf000);
		dac_note(d[11:0]);
		wr(1'b0, 5'h0e, 16'h0000);
		dac_note(d2[11:0]);
		repeat (4) @(negedge clk);
		print_verdict;
	end
endmodule
bind aioh_front_end aioh_chk #(.RES_W(RES_W), .DAC_W(DAC_W)) u_chk (
	.clk, .sys_rst, .io_addr, .io_sel_n, .io_rd_n, .io_wr_n, .io_word,
	.io_rdata_oe_r, .fifo_pop_r, .fifo_push_r, .fifo_push_data_r, .adc_done,
	.adc_result, .adc_start_r, .adc_channel_r, .channel_gain_code_r,
	.ct1_out, .ct2_out, .ct2_clk_r, .ct2_pin_r, .counter0_clock_select_r,
	.dac_code_r);
`default_nettype wire
